// *** hw/lintmc_pkg.sv ***
// Package of constants and types for the LIN transceiver mode control.
// Summary of operation
// RQ1: Starts off after reset; off allowed always and stops all bus activity.
// RQ2: In off mode bus wake patterns are ignored entirely.
// RQ3: Host writes mode field; device applies the written mode.
// RQ4: Normal transceiver mode may be entered by a write in chip normal mode.
// RQ5: Normal transceiver mode is supported only in chip normal or stop mode.
// RQ6: In normal mode transmit input level drives bus; low gives dominant.
// RQ7: Receive output shows bus state as a digital level.
// RQ8: Host keeps transmit input high until enabling time has elapsed.
// RQ9: Host driving low early must return high until enabling time ends.
// RQ10: Low present at end of enabling time is not sent; wait next fall.
// RQ11: Receive-only mode keeps driver off but still updates receive output.
// RQ12: Receive-only mode is selectable by write in chip normal or stop mode.
// RQ13: Field 01 selects wake mode; after wake it reads 01, receive held low.
// RQ14: Writes of a mode unsupported in current chip mode are ignored.
package lintmc_pkg;

    // Transceiver mode field encodings.
    localparam logic [1:0] LIN_MODE_OFF = 2'h0;
    localparam logic [1:0] LIN_MODE_WAKE = 2'h1;
    localparam logic [1:0] LIN_MODE_RXONLY = 2'h2;
    localparam logic [1:0] LIN_MODE_NORMAL = 2'h3;
    localparam logic [1:0] LIN_MODE_RESET = LIN_MODE_OFF;

    // Chip operating modes.
    localparam logic [2:0] CHIP_NORMAL = 3'h0;
    localparam logic [2:0] CHIP_STOP = 3'h1;
    localparam logic [2:0] CHIP_SLEEP = 3'h2;
    localparam logic [2:0] CHIP_RESTART = 3'h3;
    localparam logic [2:0] CHIP_FAILSAFE = 3'h4;

    // Clock and enabling time.
    localparam int CLK_HZ = 25000000;
    localparam int EN_TIME_US = 13;
    localparam int EN_CYCLES = (EN_TIME_US * (CLK_HZ / 1000000));
    localparam int EN_CNT_W = 9;

    typedef enum logic [1:0] {
        LINTMC_TX_IDLE,
        LINTMC_TX_ENABLING,
        LINTMC_TX_ARMED,
        LINTMC_TX_ACTIVE
    } lintmc_tx_e;

endpackage

// *** hw/lintmc_gate_if.sv ***
// Interface between mode control and the transmit gate.
`timescale 1ns/10ps
interface lintmc_gate_if;
    logic enable;
    logic tx_data;
    logic drive_dom;
    logic ready;
    modport ctrl (output enable, output tx_data, input drive_dom, input ready);
    modport gate (input enable, input tx_data, output drive_dom, output ready);
endinterface

// *** hw/lintmc_tx_gate.sv ***
// Transmit gate that holds off transmission through the enabling time.
`timescale 1ns/10ps
module lintmc_tx_gate #(
    parameter int EN_CYCLES = lintmc_pkg::EN_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    lintmc_gate_if.gate gif
);
    lintmc_pkg::lintmc_tx_e state_q;
    logic [lintmc_pkg::EN_CNT_W-1:0] cnt_q;
    logic [lintmc_pkg::EN_CNT_W:0] en_age_q;

    // =========================================================
    // Enabling sequence
    // RQ10 next falling edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= lintmc_pkg::LINTMC_TX_IDLE;
            cnt_q <= '0;
        end else if (!gif.enable) begin
            state_q <= lintmc_pkg::LINTMC_TX_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                lintmc_pkg::LINTMC_TX_IDLE: begin
                    state_q <= lintmc_pkg::LINTMC_TX_ENABLING;
                    cnt_q <= '0;
                end
                lintmc_pkg::LINTMC_TX_ENABLING: begin
                    if (cnt_q == lintmc_pkg::EN_CNT_W'(EN_CYCLES - 1)) begin
                        state_q <= lintmc_pkg::LINTMC_TX_ARMED;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                lintmc_pkg::LINTMC_TX_ARMED: begin
                    // A low left over from before the end is not sent.
                    if (gif.tx_data) begin
                        state_q <= lintmc_pkg::LINTMC_TX_ACTIVE;
                    end
                end
                lintmc_pkg::LINTMC_TX_ACTIVE: begin
                    state_q <= lintmc_pkg::LINTMC_TX_ACTIVE;
                end
            endcase
        end
    end

    // RQ6 pass transmit level
    assign gif.drive_dom = (state_q == lintmc_pkg::LINTMC_TX_ACTIVE)
                           && gif.enable && !gif.tx_data;
    assign gif.ready = (state_q == lintmc_pkg::LINTMC_TX_ACTIVE);

    // =========================================================
    // Checks
    // Cycles since enable, kept apart from the gate's own counter.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_age_q <= '0;
        end else if (!gif.enable) begin
            en_age_q <= '0;
        end else if (en_age_q != '1) begin
            en_age_q <= en_age_q + 1'b1;
        end
    end

    // RQ10 no early drive
    early_drive_a: assert property ( // RQ10
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_q != lintmc_pkg::LINTMC_TX_ACTIVE) |-> !gif.drive_dom)
        else $error("dominant driven before armed high");
    // RQ10 enabling length
    enable_len_a: assert property ( // RQ10
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(state_q == lintmc_pkg::LINTMC_TX_ARMED)
        |-> int'(en_age_q) == EN_CYCLES + 1)
        else $error("enabling phase length wrong");
    armed_cv: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == lintmc_pkg::LINTMC_TX_ARMED && !gif.tx_data);
endmodule

// *** hw/lintmc_top.sv ***
// Mode control of a single-wire LIN transceiver.
`timescale 1ns/10ps
module lintmc_top #(
    parameter int EN_CYCLES = lintmc_pkg::EN_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [2:0] supply_chip_mode_in,
    input wire logic mode_wr_in,
    input wire logic [1:0] mode_wdata_in,
    input wire logic lin_tx_input_in,
    input wire logic bus_rx_in,
    input wire logic bus_wake_in,
    output logic [1:0] lin_mode_field_out,
    output logic lin_rxd_out,
    output logic bus_drive_dom_out,
    output logic rx_enable_out,
    output logic wake_flag_out,
    output logic tx_ready_out
);
    logic rst_s1_q;
    logic rst_n;
    logic [1:0] mode_q;
    logic wake_q;
    logic rxd_q;
    logic mode_ok;
    logic [2:0] chip_q;
    lintmc_gate_if gif ();

    // =========================================================
    // Reset release
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // =========================================================
    // Mode select
    // RQ5 RQ12 RQ14 mode support check
    always_comb begin
        unique case (mode_wdata_in)
            lintmc_pkg::LIN_MODE_NORMAL,
            lintmc_pkg::LIN_MODE_RXONLY: begin
                mode_ok = (supply_chip_mode_in == lintmc_pkg::CHIP_NORMAL)
                       || (supply_chip_mode_in == lintmc_pkg::CHIP_STOP);
            end
            lintmc_pkg::LIN_MODE_WAKE: begin
                mode_ok = 1'b1;
            end
            lintmc_pkg::LIN_MODE_OFF: begin
                mode_ok = 1'b1;
            end
        endcase
    end

    // RQ1 RQ3 RQ4 apply mode
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= lintmc_pkg::LIN_MODE_RESET;
        end else if (mode_wr_in && mode_ok) begin
            mode_q <= mode_wdata_in;
        end else if ((mode_q != lintmc_pkg::LIN_MODE_OFF)
                     && (mode_q != lintmc_pkg::LIN_MODE_WAKE)
                     && (supply_chip_mode_in != lintmc_pkg::CHIP_NORMAL)
                     && (supply_chip_mode_in != lintmc_pkg::CHIP_STOP)) begin
            // Leaving normal/stop drops an unsupported transceiver mode.
            mode_q <= lintmc_pkg::LIN_MODE_OFF;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            chip_q <= lintmc_pkg::CHIP_NORMAL;
        end else begin
            chip_q <= supply_chip_mode_in;
        end
    end

    // =========================================================
    // Wake handling
    // RQ2 RQ13 wake latch
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wake_q <= 1'b0;
        end else if (mode_q != lintmc_pkg::LIN_MODE_WAKE) begin
            wake_q <= 1'b0;
        end else if (bus_wake_in) begin
            wake_q <= 1'b1;
        end else if (mode_wr_in && mode_ok) begin
            wake_q <= 1'b0;
        end else if (chip_q != supply_chip_mode_in
                     && (supply_chip_mode_in == lintmc_pkg::CHIP_STOP
                      || supply_chip_mode_in == lintmc_pkg::CHIP_SLEEP
                      || supply_chip_mode_in == lintmc_pkg::CHIP_FAILSAFE))
        begin
            // Entering a low-power chip mode rearms wake capability.
            wake_q <= 1'b0;
        end
    end

    // =========================================================
    // Receive path
    // RQ7 RQ11 receive level
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rxd_q <= 1'b1;
        end else if (wake_q && mode_q == lintmc_pkg::LIN_MODE_WAKE) begin
            rxd_q <= 1'b0;
        end else if (mode_q == lintmc_pkg::LIN_MODE_NORMAL
                     || mode_q == lintmc_pkg::LIN_MODE_RXONLY) begin
            rxd_q <= bus_rx_in;
        end else begin
            rxd_q <= 1'b1;
        end
    end

    // =========================================================
    // Transmit path
    // RQ11 driver only in normal
    assign gif.enable = (mode_q == lintmc_pkg::LIN_MODE_NORMAL);
    assign gif.tx_data = lin_tx_input_in;

    lintmc_tx_gate #(
        .EN_CYCLES(EN_CYCLES)
    ) u_gate (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .gif(gif)
    );

    assign lin_mode_field_out = mode_q;
    assign lin_rxd_out = rxd_q;
    assign bus_drive_dom_out = gif.drive_dom;
    assign rx_enable_out = (mode_q == lintmc_pkg::LIN_MODE_NORMAL)
                        || (mode_q == lintmc_pkg::LIN_MODE_RXONLY);
    assign wake_flag_out = wake_q;
    assign tx_ready_out = gif.ready;

    // =========================================================
    // Checks
    // RQ1 off after reset
    reset_off_a: assert property ( // RQ1
        @(posedge ref_clk_in)
        $rose(rst_n) |-> lin_mode_field_out == lintmc_pkg::LIN_MODE_OFF)
        else $error("mode not off after reset");
    // RQ2 off ignores wake
    off_wake_a: assert property ( // RQ2
        @(posedge ref_clk_in) disable iff (!rst_n)
        (mode_q == lintmc_pkg::LIN_MODE_OFF && bus_wake_in && !mode_wr_in)
        |=> !wake_q && mode_q == lintmc_pkg::LIN_MODE_OFF)
        else $error("wake acted on in off mode");
    // RQ3 write applied
    write_apply_a: assert property ( // RQ3
        @(posedge ref_clk_in) disable iff (!rst_n)
        (mode_wr_in && mode_ok) |=> mode_q == $past(mode_wdata_in))
        else $error("written mode not applied");
    // RQ4 normal write allowed
    normal_wr_a: assert property ( // RQ4
        @(posedge ref_clk_in) disable iff (!rst_n)
        (mode_wr_in && mode_wdata_in == lintmc_pkg::LIN_MODE_NORMAL
         && supply_chip_mode_in == lintmc_pkg::CHIP_NORMAL)
        |=> mode_q == lintmc_pkg::LIN_MODE_NORMAL)
        else $error("normal mode refused in chip normal");
    // RQ5 RQ12 RQ14 refused write
    refuse_wr_a: assert property ( // RQ5 RQ12 RQ14
        @(posedge ref_clk_in) disable iff (!rst_n)
        (mode_wr_in
         && (mode_wdata_in == lintmc_pkg::LIN_MODE_NORMAL
          || mode_wdata_in == lintmc_pkg::LIN_MODE_RXONLY)
         && supply_chip_mode_in != lintmc_pkg::CHIP_NORMAL
         && supply_chip_mode_in != lintmc_pkg::CHIP_STOP
         && mode_q != lintmc_pkg::LIN_MODE_NORMAL
         && mode_q != lintmc_pkg::LIN_MODE_RXONLY)
        |=> mode_q == $past(mode_q))
        else $error("unsupported mode accepted");
    // RQ11 rx only no drive
    rxonly_nodrv_a: assert property ( // RQ11
        @(posedge ref_clk_in) disable iff (!rst_n)
        mode_q != lintmc_pkg::LIN_MODE_NORMAL |-> !bus_drive_dom_out)
        else $error("driver active outside normal");
    // RQ7 receive follows bus
    rx_follow_a: assert property ( // RQ7
        @(posedge ref_clk_in) disable iff (!rst_n)
        (rx_enable_out && !wake_q) ##1 !wake_q
        |-> lin_rxd_out == $past(bus_rx_in))
        else $error("receive output not following bus");
    // RQ13 wake holds rxd low
    wake_rxd_a: assert property ( // RQ13
        @(posedge ref_clk_in) disable iff (!rst_n)
        (wake_q && mode_q == lintmc_pkg::LIN_MODE_WAKE)
        |=> !lin_rxd_out
        && (lin_mode_field_out == lintmc_pkg::LIN_MODE_WAKE
            || $past(mode_wr_in)))
        else $error("wake did not hold receive low");
    // RQ6 dominant follows low
    tx_pass_a: assert property ( // RQ6
        @(posedge ref_clk_in) disable iff (!rst_n)
        (tx_ready_out && gif.enable) |-> bus_drive_dom_out == !lin_tx_input_in)
        else $error("transmit level not passed");

    normal_cv: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
        tx_ready_out && bus_drive_dom_out);
    rxonly_cv: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
        mode_q == lintmc_pkg::LIN_MODE_RXONLY && !lin_rxd_out);
    wake_cv: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
        $rose(wake_q));
endmodule

// *** verification/lintmc_bus_model.sv ***
// Behavioural LIN bus with pull-up, a second node and a wake source.
`timescale 1ns/10ps
module lintmc_bus_model (
    input wire logic drive_dom_in,
    input wire logic node_dom_in,
    input wire logic wake_req_in,
    output logic bus_rx_out,
    output logic bus_wake_out
);
    // ==========================================================
    // Bus wiring
    // The pull-up leaves the wire recessive unless a node pulls it low.
    assign bus_rx_out = !(drive_dom_in || node_dom_in);
    assign bus_wake_out = wake_req_in;
endmodule

// *** verification/lin_transceiver_mode_control_tb.sv ***
// Self-checking bench for the LIN transceiver mode control.
`timescale 1ns/10ps
module lin_transceiver_mode_control_tb;
    // A short enabling time keeps the run brief; waits follow from it.
    localparam int EN = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] chip = lintmc_pkg::CHIP_NORMAL;
    logic wr = 1'b0;
    logic [1:0] wdata = lintmc_pkg::LIN_MODE_OFF;
    logic tx = 1'b1;
    logic node_dom = 1'b0;
    logic wake_req = 1'b0;
    logic bus_rx;
    logic bus_wake;
    logic [1:0] mode;
    logic rxd;
    logic drive;
    logic rx_en;
    logic wake;
    logic ready;
    int err_count = 0;
    int n_checks = 0;

    // ==========================================================
    // Clock, design and bus
    initial begin
        forever #20 clk = ~clk;
    end

    lintmc_top #(.EN_CYCLES(EN)) u_dut (
        .ref_clk_in(clk), .arst_n_in(arst_n), .supply_chip_mode_in(chip),
        .mode_wr_in(wr), .mode_wdata_in(wdata), .lin_tx_input_in(tx),
        .bus_rx_in(bus_rx), .bus_wake_in(bus_wake),
        .lin_mode_field_out(mode), .lin_rxd_out(rxd),
        .bus_drive_dom_out(drive), .rx_enable_out(rx_en),
        .wake_flag_out(wake), .tx_ready_out(ready)
    );

    lintmc_bus_model u_bus (
        .drive_dom_in(drive), .node_dom_in(node_dom),
        .wake_req_in(wake_req), .bus_rx_out(bus_rx), .bus_wake_out(bus_wake)
    );

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [1:0] seen, input logic [1:0] exp,
                         input string what);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s is %b not %b", $time, what, seen,
                     exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic write_mode(input logic [1:0] m);
        @(posedge clk);
        wr <= 1'b1;
        wdata <= m;
        @(posedge clk);
        wr <= 1'b0;
        cycles(2);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check(mode, lintmc_pkg::LIN_MODE_OFF, "mode");
        check(2'(rxd), 2'h1, "rxd");
        check(2'(drive), 2'h0, "drive");
        check(2'(ready), 2'h0, "ready");
        $display("test reset done");
    endtask

    task automatic t_modes();
        logic ok;
        logic [1:0] exp;
        for (int c = 0; c <= 4; c++) begin
            @(posedge clk);
            chip <= 3'(c);
            cycles(2);
            ok = (c < 2);
            write_mode(lintmc_pkg::LIN_MODE_OFF);
            check(mode, lintmc_pkg::LIN_MODE_OFF, "off");
            write_mode(lintmc_pkg::LIN_MODE_RXONLY);
            exp = ok ? lintmc_pkg::LIN_MODE_RXONLY : lintmc_pkg::LIN_MODE_OFF;
            check(mode, exp, "rx-only");
            write_mode(lintmc_pkg::LIN_MODE_NORMAL);
            exp = ok ? lintmc_pkg::LIN_MODE_NORMAL : lintmc_pkg::LIN_MODE_OFF;
            check(mode, exp, "normal");
            // A refused write leaves the wake mode in place.
            write_mode(lintmc_pkg::LIN_MODE_WAKE);
            write_mode(lintmc_pkg::LIN_MODE_RXONLY);
            exp = ok ? lintmc_pkg::LIN_MODE_RXONLY : lintmc_pkg::LIN_MODE_WAKE;
            check(mode, exp, "kept");
        end
        @(posedge clk);
        chip <= lintmc_pkg::CHIP_NORMAL;
        write_mode(lintmc_pkg::LIN_MODE_OFF);
        $display("test modes done");
    endtask

    task automatic t_enable();
        // The host pulls low too early, then returns high.
        @(posedge clk);
        tx <= 1'b0;
        write_mode(lintmc_pkg::LIN_MODE_NORMAL);
        check(mode, lintmc_pkg::LIN_MODE_NORMAL, "write");
        check(2'(rx_en), 2'h1, "rx enable");
        cycles(EN + 4);
        check(2'(ready), 2'h0, "early ready");
        check(2'(drive), 2'h0, "stale low");
        @(posedge clk);
        tx <= 1'b1;
        cycles(3);
        check(2'(ready), 2'h1, "ready");
        @(posedge clk);
        tx <= 1'b0;
        #1;
        check(2'(drive), 2'h1, "dominant");
        cycles(2);
        check(2'(rxd), 2'h0, "rxd low");
        @(posedge clk);
        tx <= 1'b1;
        #1;
        check(2'(drive), 2'h0, "recessive");
        cycles(2);
        check(2'(rxd), 2'h1, "rxd high");
        $display("test enable done");
    endtask

    task automatic t_entime();
        // With the input held high, ready follows the enabling time exactly.
        write_mode(lintmc_pkg::LIN_MODE_OFF);
        check(2'(ready), 2'h0, "ready off");
        write_mode(lintmc_pkg::LIN_MODE_NORMAL);
        cycles(EN - 1);
        check(2'(ready), 2'h0, "ready early");
        cycles(1);
        check(2'(ready), 2'h1, "ready on time");
        $display("test enabling time done");
    endtask

    task automatic t_rerst();
        // A reset in mid-run, taken from normal mode with ready high.
        @(posedge clk);
        arst_n <= 1'b0;
        cycles(2);
        check(mode, lintmc_pkg::LIN_MODE_OFF, "mode in reset");
        check(2'(ready), 2'h0, "ready in reset");
        check(2'(drive), 2'h0, "drive in reset");
        check(2'(rxd), 2'h1, "rxd in reset");
        @(posedge clk);
        arst_n <= 1'b1;
        cycles(2);
        check(mode, lintmc_pkg::LIN_MODE_OFF, "mode after reset");
        check(2'(ready), 2'h0, "ready after reset");
        write_mode(lintmc_pkg::LIN_MODE_NORMAL);
        check(mode, lintmc_pkg::LIN_MODE_NORMAL, "write after reset");
        $display("test mid-run reset done");
    endtask

    task automatic t_rxonly();
        write_mode(lintmc_pkg::LIN_MODE_RXONLY);
        @(posedge clk);
        tx <= 1'b0;
        node_dom <= 1'b1;
        cycles(2);
        check(2'(drive), 2'h0, "driver");
        check(2'(rxd), 2'h0, "rxd");
        @(posedge clk);
        node_dom <= 1'b0;
        cycles(2);
        check(2'(rxd), 2'h1, "rxd");
        $display("test rx-only done");
    endtask

    task automatic t_off();
        write_mode(lintmc_pkg::LIN_MODE_OFF);
        @(posedge clk);
        node_dom <= 1'b1;
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        cycles(3);
        check(2'(drive), 2'h0, "drive");
        check(2'(rxd), 2'h1, "rxd");
        check(2'(wake), 2'h0, "wake");
        check(mode, lintmc_pkg::LIN_MODE_OFF, "mode");
        @(posedge clk);
        node_dom <= 1'b0;
        tx <= 1'b1;
        $display("test off done");
    endtask

    task automatic t_wake();
        write_mode(lintmc_pkg::LIN_MODE_WAKE);
        check(mode, lintmc_pkg::LIN_MODE_WAKE, "mode");
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        cycles(3);
        check(2'(wake), 2'h1, "wake");
        check(2'(rxd), 2'h0, "rxd");
        check(mode, lintmc_pkg::LIN_MODE_WAKE, "mode");
        write_mode(lintmc_pkg::LIN_MODE_OFF);
        check(2'(rxd), 2'h1, "rxd");
        $display("test wake done");
    endtask

    // ==========================================================
    // Sequence and watchdog
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        cycles(3);
        t_reset();
        t_modes();
        t_enable();
        t_entime();
        t_rerst();
        t_rxonly();
        t_off();
        t_wake();
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        $display("MISMATCH at %0t: watchdog ran out", $time);
        end_sim();
    end
endmodule
